//--- verilog/pxs_serializer.sv
/*
 Seven-to-one pixel serializer top: 28 parallel bits captured on the chosen
 pixel clock edge, handed to the link clock and sent over four data lanes
 and one forwarded clock lane.
 Assumes the pixel clock, data and edge select arrive asynchronously to
 mclk, and that bitClk is the seven-times bit clock made outside.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pxs_cfg.svh"

module pxs_serializer #(
	parameter bit SHIFT_MSB_FIRST = 1'b1
) (
	// System clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Link bit clock
	input wire logic bitClk,
	// Parallel pixel side
	input wire logic pixelClockIn,
	input wire logic captureEdgeSelect,
	input wire pxs_pkg::pxs_word_t pixelBits,
	input wire logic shutdownClearN,
	// Serial side
	output pxs_pkg::pxs_link_t linkOut
);

	// Shutdown joins the reset so every register clears while it is low
	wire clearAllN = resetn & shutdownClearN;

	logic [1:0] mclkRstSync;
	logic [1:0] linkRstSync;
	wire mclkRstN = mclkRstSync[1];
	wire linkRstN = linkRstSync[1];

	always_ff @(posedge mclk or negedge clearAllN) begin
		if (!clearAllN) begin
			mclkRstSync <= 2'h0;
		end else begin
			mclkRstSync <= {mclkRstSync[0], 1'b1};
		end
	end

	// Holding the link side in reset stops shifting and drops the drivers
	always_ff @(posedge bitClk or negedge clearAllN) begin
		if (!clearAllN) begin
			linkRstSync <= 2'h0;
		end else begin
			linkRstSync <= {linkRstSync[0], 1'b1};
		end
	end

	// Two-stage synchronisers on every pin input
	logic pixClkMeta;
	logic pixClkSync;
	logic pixClkPrev;
	logic edgeSelMeta;
	logic edgeSel;
	pxs_pkg::pxs_word_t bitsMeta;
	pxs_pkg::pxs_word_t bitsSync;

	always_ff @(posedge mclk or negedge mclkRstN) begin
		if (!mclkRstN) begin
			pixClkMeta <= 1'b0;
			pixClkSync <= 1'b0;
			pixClkPrev <= 1'b0;
			edgeSelMeta <= 1'b0;
			edgeSel <= 1'b0;
			bitsMeta <= `PXS_WORD_RESET;
			bitsSync <= `PXS_WORD_RESET;
		end else begin
			pixClkMeta <= pixelClockIn;
			pixClkSync <= pixClkMeta;
			pixClkPrev <= pixClkSync;
			edgeSelMeta <= captureEdgeSelect;
			edgeSel <= edgeSelMeta;
			bitsMeta <= pixelBits;
			bitsSync <= bitsMeta;
		end
	end

	wire pixRise = pixClkSync & ~pixClkPrev;
	wire pixFall = ~pixClkSync & pixClkPrev;
	// Each pixel edge of the selected polarity is taken on its own, so frequency drift is followed
	wire captureNow = edgeSel ? pixRise : pixFall;

	pxs_pkg::pxs_word_t holdWord;
	logic reqToggle;

	// Whole word held, toggle announces it to the link domain
	always_ff @(posedge mclk or negedge mclkRstN) begin
		if (!mclkRstN) begin
			holdWord <= `PXS_WORD_RESET;
			reqToggle <= 1'b0;
		end else if (captureNow) begin
			holdWord <= bitsSync;
			reqToggle <= ~reqToggle;
		end
	end

	pxs_lane_shifter #(
		.SHIFT_MSB_FIRST(SHIFT_MSB_FIRST)
	) u_shifter (
		.bitClk(bitClk),
		.linkRstN(linkRstN),
		.holdWord(holdWord),
		.reqToggle(reqToggle),
		.linkOut(linkOut)
	);

	chk_capture_rise: assert property (@(posedge mclk) disable iff (!mclkRstN)
		edgeSel && pixRise |=> holdWord == $past(bitsSync))
		else $error("rising edge capture missed");

	chk_capture_fall: assert property (@(posedge mclk) disable iff (!mclkRstN)
		!edgeSel && pixFall |=> holdWord == $past(bitsSync))
		else $error("falling edge capture missed");

	chk_hold_stable: assert property (@(posedge mclk) disable iff (!mclkRstN)
		!captureNow |=> $stable(holdWord) && $stable(reqToggle))
		else $error("holding word changed without a capture edge");

	chk_toggle_capture: assert property (@(posedge mclk) disable iff (!mclkRstN)
		captureNow |=> reqToggle != $past(reqToggle))
		else $error("capture not announced to link domain");

	chk_shutdown_clear: assert property (@(posedge mclk) disable iff (!resetn)
		!shutdownClearN ##1 !shutdownClearN |-> holdWord == `PXS_WORD_RESET && !reqToggle)
		else $error("shutdown did not clear holding register");

	chk_shutdown_drv: assert property (@(posedge bitClk) disable iff (!resetn)
		!shutdownClearN ##1 !shutdownClearN |-> !linkOut.forwardedClockLaneOe
			&& linkOut.laneDataOe == 4'h0)
		else $error("drivers enabled during shutdown");

endmodule : pxs_serializer
`default_nettype wire

//--- verilog/pxs_cfg.svh
/*
 Constants of the seven-to-one pixel serializer: word layout, lane timing,
 clock-lane pattern and the pixel clock window.
 Assumes it is included by its bare name wherever these values are needed.
*/
`ifndef PXS_CFG_SVH
`define PXS_CFG_SVH

`define PXS_WORD_BITS 28
`define PXS_LANES 4
`define PXS_SLICE_BITS 7
`define PXS_SLOT_LAST 3'h6
`define PXS_SLOT_FIRST 3'h0
`define PXS_CLK_PATTERN 7'h63
`define PXS_WORD_RESET 28'h0000000
`define PXS_MCLK_MHZ 125
`define PXS_PIX_MIN_MHZ 10
`define PXS_PIX_MAX_MHZ 135
`define PXS_SYNC_STAGES 2

`endif

//--- verilog/pxs_pkg.sv
/*
 Types of the seven-to-one pixel serializer.
 Assumes pxs_cfg.svh is reachable on the include path.
*/
`include "pxs_cfg.svh"

package pxs_pkg;

	typedef logic [`PXS_WORD_BITS-1:0] pxs_word_t;
	typedef logic [`PXS_SLICE_BITS-1:0] pxs_slice_t;
	typedef logic [2:0] pxs_slot_t;

	// Serial side as seen at the pins; enables are high while driving
	typedef struct packed {
		logic [`PXS_LANES-1:0] laneData;
		logic [`PXS_LANES-1:0] laneDataOe;
		logic forwardedClockLane;
		logic forwardedClockLaneOe;
	} pxs_link_t;

endpackage : pxs_pkg

//--- verilog/pxs_lane_shifter.sv
/*
 Link-domain half of the serializer: takes the captured pixel word across
 from the system clock, and shifts four data lanes plus the clock lane.
 Assumes bitClk runs at seven times the pixel rate and linkRstN is already
 synchronised to bitClk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pxs_cfg.svh"

module pxs_lane_shifter #(
	parameter bit SHIFT_MSB_FIRST = 1'b1
) (
	// Link clock and reset
	input wire logic bitClk,
	input wire logic linkRstN,
	// Word handed over from the system clock
	input wire pxs_pkg::pxs_word_t holdWord,
	input wire logic reqToggle,
	// Pins
	output pxs_pkg::pxs_link_t linkOut
);

	logic [`PXS_SYNC_STAGES-1:0] toggleSync;
	logic togglePrev;
	pxs_pkg::pxs_word_t curWord;
	pxs_pkg::pxs_slot_t slot;
	pxs_pkg::pxs_slice_t shiftReg [`PXS_LANES];
	pxs_pkg::pxs_slice_t clkShift;
	logic driveOn;

	wire newWord = toggleSync[1] != togglePrev;
	wire slotEnd = slot == `PXS_SLOT_LAST;

	// Fixed lane table; bit order set by SHIFT_MSB_FIRST, matching the companion receiver only when it is 1
	function automatic pxs_pkg::pxs_slice_t sliceOf(input pxs_pkg::pxs_word_t w,
		input int lane);
		pxs_pkg::pxs_slice_t s;
		s = w[lane*`PXS_SLICE_BITS +: `PXS_SLICE_BITS];
		if (!SHIFT_MSB_FIRST) begin
			s = {<<{s}};
		end
		return s;
	endfunction : sliceOf

	// Toggle crossing; the word is stable long before the toggle lands
	always_ff @(posedge bitClk or negedge linkRstN) begin
		if (!linkRstN) begin
			toggleSync <= '0;
			togglePrev <= 1'b0;
			curWord <= `PXS_WORD_RESET;
		end else begin
			toggleSync <= {toggleSync[0], reqToggle};
			togglePrev <= toggleSync[1];
			if (newWord) begin
				curWord <= holdWord;
			end
		end
	end

	// Seven bit slots per pixel period
	always_ff @(posedge bitClk or negedge linkRstN) begin
		if (!linkRstN) begin
			slot <= `PXS_SLOT_FIRST;
			driveOn <= 1'b0;
		end else begin
			slot <= slotEnd ? `PXS_SLOT_FIRST : slot + 3'h1;
			driveOn <= 1'b1;
		end
	end

	// Four parallel-load shift registers, one per lane
	for (genvar l = 0; l < `PXS_LANES; l++) begin : g_lane
		always_ff @(posedge bitClk or negedge linkRstN) begin
			if (!linkRstN) begin
				shiftReg[l] <= '0;
			end else if (slotEnd) begin
				shiftReg[l] <= sliceOf(curWord, l);
			end else begin
				shiftReg[l] <= {shiftReg[l][`PXS_SLICE_BITS-2:0], 1'b0};
			end
		end
		assign linkOut.laneData[l] = shiftReg[l][`PXS_SLICE_BITS-1];
		assign linkOut.laneDataOe[l] = driveOn;
	end

	// Clock lane shifted from the same slot counter keeps it locked to data
	always_ff @(posedge bitClk or negedge linkRstN) begin
		if (!linkRstN) begin
			clkShift <= '0;
		end else if (slotEnd) begin
			clkShift <= `PXS_CLK_PATTERN;
		end else begin
			clkShift <= {clkShift[`PXS_SLICE_BITS-2:0], 1'b0};
		end
	end

	assign linkOut.forwardedClockLane = clkShift[`PXS_SLICE_BITS-1];
	assign linkOut.forwardedClockLaneOe = driveOn;

	chk_slot_wrap: assert property (@(posedge bitClk) disable iff (!linkRstN)
		slotEnd |=> slot == `PXS_SLOT_FIRST)
		else $error("slot counter did not wrap after seven bits");

	// Falling edges are used: the first group after a clear rises late, at its first bit, from all zeros
	chk_clock_period: assert property (@(posedge bitClk) disable iff (!linkRstN)
		$fell(linkOut.forwardedClockLane) |-> ##7 $fell(linkOut.forwardedClockLane))
		else $error("forwarded clock lane is not one pixel period");

	chk_lane_load: assert property (@(posedge bitClk) disable iff (!linkRstN)
		slotEnd |=> shiftReg[0] == sliceOf($past(curWord), 0)
			&& shiftReg[3] == sliceOf($past(curWord), 3))
		else $error("lane slice not loaded at slot end");

	chk_word_cross: assert property (@(posedge bitClk) disable iff (!linkRstN)
		newWord |=> curWord == $past(holdWord))
		else $error("crossed word not taken on toggle");

	chk_drive_on: assert property (@(posedge bitClk) disable iff (!linkRstN)
		$past(linkRstN) |-> linkOut.laneDataOe == 4'hf && linkOut.forwardedClockLaneOe)
		else $error("lane drivers not enabled after link reset release");

endmodule : pxs_lane_shifter
`default_nettype wire

//--- dv/pxs_rx_model.sv
/*
 Behavioural display receiver for the pixel serializer: rebuilds each
 28-bit word from the four data lanes and measures the clock lane period.
 Assumes the serializer's linkOut and bitClk are connected directly.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pxs_cfg.svh"

module pxs_rx_model (
	// Link clock
	input wire logic bitClk,
	// Serial side
	input wire pxs_pkg::pxs_link_t linkIn,
	// Recovered word and clock lane period in bits
	output pxs_pkg::pxs_word_t rxWord,
	output logic [3:0] gap
);
	logic [6:0] hist [0:4];
	logic [3:0] count = 4'h0;
	wire logic driving = (&linkIn.laneDataOe) & linkIn.forwardedClockLaneOe;
	wire logic [6:0] clkWin = {hist[4][5:0], linkIn.forwardedClockLane};

	always @(posedge bitClk) begin
		for (int l = 0; l < 4; l++) begin
			hist[l] <= {hist[l][5:0], linkIn.laneData[l]};
		end
		hist[4] <= clkWin;
		count <= count + 4'h1;
		// Clock lane pattern frames the slot group, first bit is the MSB
		if (driving && clkWin == `PXS_CLK_PATTERN) begin
			gap <= count;
			count <= 4'h1;
			for (int l = 0; l < 4; l++) begin
				rxWord[l*7 +: 7] <= {hist[l][5:0], linkIn.laneData[l]};
			end
		end
	end
endmodule : pxs_rx_model
`default_nettype wire

//--- dv/testbench.sv
/*
 Self-checking bench of the pixel serializer: reset check, table of pixel
 captures on both edge selections, then shutdown checks.
 Assumes the design files and pxs_rx_model are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none

module testbench;
	logic mclk, resetn, bitClk, pixelClockIn, captureEdgeSelect, shutdownClearN;
	pxs_pkg::pxs_word_t pixelBits, rxWord;
	pxs_pkg::pxs_link_t linkOut;
	logic [3:0] gap;
	int n_fail = 0;
	int samples_checked = 0;
	// Row 6 is 18-bit colour with the unused inputs tied low
	pxs_pkg::pxs_word_t rowD [8] = '{28'h0a5c3e1, 28'h1234567, 28'h7654321, 28'hc3a5f0e,
		28'h0000000, 28'hfffffff, 28'h77cf3df, 28'h5555555};
	pxs_pkg::pxs_word_t rowE [8] = '{28'h0a5c3e1, 28'h0a5c3e1, 28'h0a5c3e1, 28'hc3a5f0e,
		28'h0000000, 28'hfffffff, 28'h77cf3df, 28'h77cf3df};
	logic [7:0] rowSel = 8'hd3;

	initial begin
		mclk = 1'h0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		bitClk = 1'h0;
		#7;
		forever #15 bitClk = ~bitClk;
	end

	pxs_serializer u_pxs_serializer (.mclk(mclk), .resetn(resetn), .bitClk(bitClk),
		.pixelClockIn(pixelClockIn), .captureEdgeSelect(captureEdgeSelect),
		.pixelBits(pixelBits), .shutdownClearN(shutdownClearN), .linkOut(linkOut));
	pxs_rx_model u_pxs_rx_model (.bitClk(bitClk), .linkIn(linkOut), .rxWord(rxWord),
		.gap(gap));

	task automatic chkWord(input string what, input pxs_pkg::pxs_word_t exp,
		input pxs_pkg::pxs_word_t got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : chkWord

	task automatic chkSmall(input string what, input logic [9:0] exp, input logic [9:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : chkSmall

	task automatic test_done();
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done

	// Each row sets data and select, then makes one pixel clock edge
	task automatic runRow(input int i);
		@(posedge mclk);
		captureEdgeSelect <= rowSel[i];
		pixelBits <= rowD[i];
		repeat (6) @(posedge mclk);
		pixelClockIn <= ~pixelClockIn;
		repeat (28) @(posedge bitClk);
		#1;
		chkWord("rxWord", rowE[i], rxWord);
		chkSmall("clock lane period", 10'h007, {6'h00, gap});
		chkSmall("enables", 10'h01f, {5'h00, linkOut.laneDataOe,
			linkOut.forwardedClockLaneOe});
	endtask : runRow

	initial begin
		#50000;
		n_fail++;
		test_done();
	end

	initial begin
		resetn = 1'h0;
		shutdownClearN = 1'h1;
		pixelClockIn = 1'h0;
		captureEdgeSelect = 1'h1;
		pixelBits = 28'h0000000;
		repeat (8) @(posedge mclk);
		chkSmall("link in reset", 10'h000, linkOut);
		resetn <= 1'h1;
		repeat (20) @(posedge mclk);
		for (int i = 0; i < 8; i++) begin
			runRow(i);
		end
		@(posedge mclk);
		shutdownClearN <= 1'h0;
		repeat (4) @(posedge bitClk);
		#1;
		chkSmall("link in shutdown", 10'h000, linkOut);
		@(posedge mclk);
		shutdownClearN <= 1'h1;
		repeat (40) @(posedge bitClk);
		#1;
		chkWord("word after clear", 28'h0000000, rxWord);
		test_done();
	end
endmodule : testbench
`default_nettype wire
